// [atsr_consts.svh]
`ifndef ATSR_CONSTS_SVH
`define ATSR_CONSTS_SVH

// timing
`define ATSR_MCLK_PERIOD_NS  4
`define ATSR_TEMP_PERIOD_US  350
`define ATSR_TEMP_CONV_US    25
`define ATSR_NS_PER_US       1000

// frame layout
`define ATSR_FRAME_LAST_RISE 4'hF
`define ATSR_ACC_SAMPLE_RISE 4'h1
`define ATSR_ACTRL_LAST_RISE 4'h7
`define ATSR_ACC_WORD_BITS   16
`define ATSR_ACC_BITS        12
`define ATSR_TEMP_BITS       10
`define ATSR_TEMP_LAST_FALL  4'hB
`define ATSR_TEMP_TOP_IDX    4'hA

// control registers
`define ATSR_CTRL_BITS       8
`define ATSR_ACTRL_RESET     8'h04
`define ATSR_TCTRL_RESET     8'h00
`define ATSR_ACTRL_AXIS_BIT  3

`endif

// [atsr_pkg.sv]
package atsr_pkg;

	// conversion sequencer states
	typedef enum logic {
		tc_idle,
		tc_conv
	} atsr_tstate_e;

	// temperature result, two's complement, quarter degree per step
	typedef logic [9:0] atsr_temp_t;

endpackage : atsr_pkg

// [atsr_tconv_if.sv]
interface atsr_tconv_if
	import atsr_pkg::*;
(
	input wire logic mclk,
	input wire logic arst_n
);
	logic       clk_en;
	logic       access_start;
	logic       access_end;
	atsr_temp_t sensor;
	atsr_temp_t result;
	logic       upd_tgl;
	logic       lockout;
	logic       busy;

	modport ctrl (
		input  mclk, arst_n, result, upd_tgl, lockout, busy,
		output clk_en, access_start, access_end, sensor
	);

	modport conv (
		input  mclk, arst_n, clk_en, access_start, access_end, sensor,
		output result, upd_tgl, lockout, busy
	);
endinterface : atsr_tconv_if

// [atsr_tconv.sv]
`include "atsr_consts.svh"

module atsr_tconv
	import atsr_pkg::*;
#(
	parameter int unsigned PERIOD_CYC = 87500,
	parameter int unsigned CONV_CYC   = 6250
) (
	// control side
	atsr_tconv_if.conv tif
);
	localparam int unsigned TW = $clog2(PERIOD_CYC + CONV_CYC + 1);

	atsr_tstate_e state_r;
	logic [TW-1:0] tmr_r;
	logic          lockout_r;
	atsr_temp_t    result_r;
	logic          tgl_r;
	logic          period_done;
	logic          conv_done;

	assign period_done = (state_r == tc_idle) && (tmr_r == TW'(PERIOD_CYC - 1));
	assign conv_done   = (state_r == tc_conv) && (tmr_r == TW'(CONV_CYC - 1));

	// oscillator: idle count up to the period, then one timed conversion
	always_ff @(posedge tif.mclk or negedge tif.arst_n) begin
		if (!tif.arst_n) begin
			state_r <= tc_idle;
			tmr_r   <= '0;
		end else if (tif.clk_en) begin
			case (state_r)
				tc_idle: begin
					if (period_done || tif.access_end) begin
						state_r <= tc_conv;
						tmr_r   <= '0;
					end else begin
						tmr_r <= tmr_r + TW'(1);
					end
				end
				tc_conv: begin
					if (conv_done) begin
						state_r <= tc_idle;
						tmr_r   <= '0;
					end else begin
						tmr_r <= tmr_r + TW'(1);
					end
				end
				default: begin
					state_r <= tc_idle;
					tmr_r   <= '0;
				end
			endcase
		end
	end

	// lockout: an access wins over the clear at the auto start
	always_ff @(posedge tif.mclk or negedge tif.arst_n) begin
		if (!tif.arst_n) begin
			lockout_r <= 1'b0;
		end else if (tif.clk_en) begin
			if (tif.access_start && (state_r == tc_conv || period_done)) begin
				lockout_r <= 1'b1;
			end else if (period_done) begin
				lockout_r <= 1'b0;
			end
		end
	end

	// result only moves at a completed, unlocked conversion
	always_ff @(posedge tif.mclk or negedge tif.arst_n) begin
		if (!tif.arst_n) begin
			result_r <= '0;
			tgl_r    <= 1'b0;
		end else if (tif.clk_en && conv_done && !lockout_r) begin
			result_r <= tif.sensor;
			tgl_r    <= ~tgl_r;
		end
	end

	assign tif.result  = result_r;
	assign tif.upd_tgl = tgl_r;
	assign tif.lockout = lockout_r;
	assign tif.busy    = (state_r == tc_conv);
endmodule : atsr_tconv

// [atsr_top.sv]
// Behaviour
// - bit 3 picks x or y axis
// - bit 0 selects power-down
// - control register kept through power-down
// - enter power-down at once, wake on 16th rise
// - temp frame: leading zero then ten bits
// - hold last bit until deselect, then release
// - din shifted into temp control on rises
// - result is ten-bit two's complement
// - auto conversion every period, fixed length
// - output shows latest finished conversion; here only one already synchronised on earlier sclk rises
// - fast reselects repeat the same value
// - access during conversion locks result update
// - access end starts a conversion unless one is running
// - drive on falls, capture on rises
// - sample on second rise, sixteen clocks each
// - deselect releases dout, else convert again
`include "atsr_consts.svh"

module atsr_top
	import atsr_pkg::*;
#(
	parameter int unsigned TEMP_PERIOD_CYC =
		(`ATSR_TEMP_PERIOD_US * `ATSR_NS_PER_US) / `ATSR_MCLK_PERIOD_NS,
	parameter int unsigned TEMP_CONV_CYC   =
		(`ATSR_TEMP_CONV_US * `ATSR_NS_PER_US) / `ATSR_MCLK_PERIOD_NS,
	parameter int unsigned ACC_BITS        = `ATSR_ACC_BITS
) (
	// system clock and reset
	input  wire logic                   mclk,
	input  wire logic                   arst_n,
	input  wire logic                   clk_en,
	// serial link
	input  wire logic                   sclk,
	input  wire logic                   accel_select_n,
	input  wire logic                   temp_select_n,
	input  wire logic                   din,
	output logic                        dout,
	output logic                        dout_oe,
	// sensor front ends
	input  wire logic [ACC_BITS-1:0]    accel_x_sample,
	input  wire logic [ACC_BITS-1:0]    accel_y_sample,
	input  wire logic [`ATSR_TEMP_BITS-1:0] temp_sensor,
	// status toward the analog side
	output logic                        accel_axis_y,
	output logic                        accel_power_down,
	output logic [`ATSR_CTRL_BITS-1:0]  temp_ctrl,
	output logic                        temp_lockout
);
	// ---------------- link domain ----------------
	logic                        frame_rst_n;
	logic [3:0]                  rise_cnt_r;
	logic [`ATSR_CTRL_BITS-1:0]  din_sr_r;
	logic [`ATSR_CTRL_BITS-1:0]  actrl_r;
	logic [`ATSR_CTRL_BITS-1:0]  tctrl_r;
	logic                        actrl_wr;
	logic                        pd_r;
	logic                        pwrup_pend_r;
	logic [2*ACC_BITS-1:0]       acc_s1_r;
	logic [2*ACC_BITS-1:0]       acc_s2_r;
	logic [`ATSR_ACC_WORD_BITS-1:0] acc_word_r;
	logic                        tgl_s1_r;
	logic                        tgl_s2_r;
	logic                        tgl_seen_r;
	atsr_temp_t                  tshadow_r;
	atsr_temp_t                  tword_r;
	logic [3:0]                  fall_cnt_r;
	logic [3:0]                  temp_idx;
	logic [3:0]                  acc_idx;
	logic                        dout_r;
	logic                        dout_oe_r;

	// ---------------- system domain ----------------
	logic                        tcs_s1_r;
	logic                        tcs_s2_r;
	logic                        tcs_d_r;
	logic [1:0]                  ctl_s1_r;
	logic [1:0]                  ctl_s2_r;
	atsr_temp_t                  tsen_s1_r;
	atsr_temp_t                  tsen_s2_r;

	atsr_tconv_if tif (
		.mclk   (mclk),
		.arst_n (arst_n)
	);

	// frame logic is cleared whenever neither select is low, so it needs no sclk edge to end
	assign frame_rst_n = arst_n & ~(accel_select_n & temp_select_n);

	// rising-edge counter; wraps at sixteen so a held select starts the next word
	always_ff @(posedge sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			rise_cnt_r <= '0;
		end else begin
			rise_cnt_r <= rise_cnt_r + 4'h1;
		end
	end

	// din is captured on rises, the host launches it on falls
	always_ff @(posedge sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			din_sr_r <= '0;
		end else begin
			din_sr_r <= {din_sr_r[`ATSR_CTRL_BITS-2:0], din};
		end
	end

	assign actrl_wr = !accel_select_n && (rise_cnt_r == `ATSR_ACTRL_LAST_RISE);

	// accel control: fixed bits are stored as sent and never checked
	always_ff @(posedge sclk or negedge arst_n) begin
		if (!arst_n) begin
			actrl_r <= `ATSR_ACTRL_RESET;
		end else if (actrl_wr) begin
			actrl_r <= {din_sr_r[`ATSR_CTRL_BITS-2:0], din};
		end
	end

	// power mode: entry on the write edge, exit deferred to the 16th rise
	always_ff @(posedge sclk or negedge arst_n) begin
		if (!arst_n) begin
			pd_r         <= 1'b0;
			pwrup_pend_r <= 1'b0;
		end else if (actrl_wr) begin
			if (din) begin
				pd_r         <= 1'b1;
				pwrup_pend_r <= 1'b0;
			end else begin
				pwrup_pend_r <= pd_r;
			end
		end else if (pwrup_pend_r && !accel_select_n &&
		             rise_cnt_r == `ATSR_FRAME_LAST_RISE) begin
			pd_r         <= 1'b0;
			pwrup_pend_r <= 1'b0;
		end
	end

	// analog sample pins cross into the link domain through two stages
	always_ff @(posedge sclk or negedge arst_n) begin
		if (!arst_n) begin
			acc_s1_r <= '0;
			acc_s2_r <= '0;
		end else begin
			acc_s1_r <= {accel_y_sample, accel_x_sample};
			acc_s2_r <= acc_s1_r;
		end
	end

	// conversion sample taken on the second rise after select
	always_ff @(posedge sclk or negedge arst_n) begin
		if (!arst_n) begin
			acc_word_r <= '0;
		end else if (!accel_select_n && rise_cnt_r == `ATSR_ACC_SAMPLE_RISE) begin
			if (pd_r) begin
				acc_word_r <= '0;
			end else if (actrl_r[`ATSR_ACTRL_AXIS_BIT]) begin
				acc_word_r <= `ATSR_ACC_WORD_BITS'(acc_s2_r[2*ACC_BITS-1:ACC_BITS]);
			end else begin
				acc_word_r <= `ATSR_ACC_WORD_BITS'(acc_s2_r[ACC_BITS-1:0]);
			end
		end
	end

	// temp control: every rise of a temp frame shifts din in
	always_ff @(posedge sclk or negedge arst_n) begin
		if (!arst_n) begin
			tctrl_r <= `ATSR_TCTRL_RESET;
		end else if (!temp_select_n) begin
			tctrl_r <= {tctrl_r[`ATSR_CTRL_BITS-2:0], din};
		end
	end

	// result word crossing: toggle synchronised, word sampled once the toggle settles;
	// the word is stable for a whole conversion, so it cannot tear
	always_ff @(posedge sclk or negedge arst_n) begin
		if (!arst_n) begin
			tgl_s1_r   <= 1'b0;
			tgl_s2_r   <= 1'b0;
			tgl_seen_r <= 1'b0;
			tshadow_r  <= '0;
		end else begin
			tgl_s1_r <= tif.upd_tgl;
			tgl_s2_r <= tgl_s1_r;
			if (tgl_s2_r != tgl_seen_r) begin
				tgl_seen_r <= tgl_s2_r;
				tshadow_r  <= tif.result;
			end
		end
	end

	assign temp_idx = `ATSR_TEMP_TOP_IDX - fall_cnt_r;
	assign acc_idx  = `ATSR_FRAME_LAST_RISE - fall_cnt_r;

	// output side: bits launched on falling edges, released by the select's rise
	always_ff @(negedge sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			fall_cnt_r <= '0;
			dout_r     <= 1'b0;
			dout_oe_r  <= 1'b0;
			tword_r    <= '0;
		end else if (!temp_select_n) begin
			dout_oe_r <= 1'b1;
			if (fall_cnt_r == 4'h0) begin
				tword_r <= tshadow_r;
				dout_r  <= 1'b0;
			end else if (fall_cnt_r != `ATSR_TEMP_LAST_FALL) begin
				dout_r <= tword_r[temp_idx];
			end
			if (fall_cnt_r != `ATSR_TEMP_LAST_FALL) begin
				fall_cnt_r <= fall_cnt_r + 4'h1;
			end
		end else begin
			dout_oe_r  <= 1'b1;
			dout_r     <= acc_word_r[acc_idx];
			fall_cnt_r <= fall_cnt_r + 4'h1;
		end
	end

	assign dout    = dout_r;
	assign dout_oe = dout_oe_r;
	assign temp_ctrl = tctrl_r;

	// temp select seen from the system clock: two stages, then an edge detector
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			tcs_s1_r <= 1'b1;
			tcs_s2_r <= 1'b1;
			tcs_d_r  <= 1'b1;
		end else if (clk_en) begin
			tcs_s1_r <= temp_select_n;
			tcs_s2_r <= tcs_s1_r;
			tcs_d_r  <= tcs_s2_r;
		end
	end

	assign tif.clk_en       = clk_en;
	assign tif.access_start = tcs_d_r & ~tcs_s2_r;
	assign tif.access_end   = ~tcs_d_r & tcs_s2_r;

	// control levels and the sensor pins pass two stages into the system domain
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ctl_s1_r  <= '0;
			ctl_s2_r  <= '0;
			tsen_s1_r <= '0;
			tsen_s2_r <= '0;
		end else if (clk_en) begin
			ctl_s1_r  <= {pd_r, actrl_r[`ATSR_ACTRL_AXIS_BIT]};
			ctl_s2_r  <= ctl_s1_r;
			tsen_s1_r <= temp_sensor;
			tsen_s2_r <= tsen_s1_r;
		end
	end

	assign tif.sensor       = tsen_s2_r;
	assign accel_axis_y     = ctl_s2_r[0];
	assign accel_power_down = ctl_s2_r[1];
	assign temp_lockout     = tif.lockout;

	// conversion timer, lockout and result register
	atsr_tconv #(
		.PERIOD_CYC (TEMP_PERIOD_CYC),
		.CONV_CYC   (TEMP_CONV_CYC)
	) u_tconv (
		.tif (tif.conv)
	);
endmodule : atsr_top

// [atsr_chk.sv]
`include "atsr_consts.svh"

module atsr_chk (
	// clocks and reset
	input wire logic                       mclk,
	input wire logic                       arst_n,
	input wire logic                       sclk,
	// link
	input wire logic                       accel_select_n,
	input wire logic                       temp_select_n,
	input wire logic                       din,
	input wire logic                       dout,
	input wire logic                       dout_oe,
	// status
	input wire logic                       accel_axis_y,
	input wire logic                       accel_power_down,
	input wire logic [`ATSR_CTRL_BITS-1:0] temp_ctrl,
	input wire logic                       temp_lockout
);
	logic [4:0] falls_r;
	logic [6:0] ctrl_low;

	// falls in the current temp frame; deselect clears it so no count leaks
	always_ff @(negedge sclk or posedge temp_select_n) begin
		if (temp_select_n)
			falls_r <= 5'h00;
		else if (falls_r != 5'h1F)
			falls_r <= falls_r + 5'h01;
	end

	assign ctrl_low = temp_ctrl[6:0];

	oe_release_a: assert property (@(posedge mclk) disable iff (!arst_n)
		accel_select_n && temp_select_n |-> !dout_oe) else $error("dout left driven");
	temp_lead_a: assert property (@(posedge sclk) disable iff (!arst_n)
		!temp_select_n && falls_r == 5'h01 |-> dout_oe && !dout) else $error("no leading zero");
	temp_hold_a: assert property (@(posedge sclk) disable iff (!arst_n)
		!temp_select_n && falls_r > 5'h0B |-> $stable(dout)) else $error("last bit not held");
	ctrl_shift_a: assert property (@(posedge sclk) disable iff (!arst_n)
		!temp_select_n && falls_r > 5'h02 |-> temp_ctrl == {$past(ctrl_low), $past(din)})
		else $error("temp control not shifted");
	oe_frame_a: assert property (@(posedge sclk) disable iff (!arst_n)
		!temp_select_n || !accel_select_n |-> dout_oe) else $error("dout not driven");
	lock_cause_a: assert property (@(posedge mclk) disable iff (!arst_n)
		$rose(temp_lockout) |-> !temp_select_n) else $error("lockout without access");
	mode_chg_a: assert property (@(posedge mclk) disable iff (!arst_n)
		!$stable(accel_power_down) || !$stable(accel_axis_y) |-> !accel_select_n)
		else $error("mode changed outside frame");
	drive_fall_a: assert property (@(posedge mclk) disable iff (!arst_n)
		$changed(dout) |-> !sclk || (accel_select_n && temp_select_n))
		else $error("dout moved off a falling edge");
endmodule : atsr_chk

// [atsr_host.sv]
module atsr_host (
	// link toward the device
	output logic      sclk,
	output logic      accel_select_n,
	output logic      temp_select_n,
	output logic      din,
	input  wire logic dout
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] rx;
	event        got;

	// idle: clock parked high, both selects off
	initial begin
		sclk = 1'b1;
		accel_select_n = 1'b1;
		temp_select_n = 1'b1;
		din = 1'b0;
	end

	// one frame, msb first; din flips afterwards so a stale level never passes
	// din takes its first bit before select, so a temp frame sees only zeros
	// limitation: accel frames come back to back, far above the slow-sampling advice;
	// the front end modelled here is digital and has no filter charge to drain
	task automatic xfer(input logic acc, input logic [15:0] tx);
		#2.3;
		din = tx[15];
		if (acc)
			accel_select_n = 1'b0;
		else
			temp_select_n = 1'b0;
		#24;
		for (int i = 15; i >= 0; i--) begin
			sclk = 1'b0;
			din = tx[i];
			#24;
			sclk = 1'b1;
			rx[i] = dout;
			#24;
		end
		accel_select_n = 1'b1;
		temp_select_n = 1'b1;
		din = ~din;
		-> got;
	endtask : xfer
endmodule : atsr_host

// [atsr_bench.sv]
`include "atsr_consts.svh"

module atsr_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic                 mclk, arst_n, sclk, acc_n, tmp_n, din, dout, dout_oe, ay, apd, lock, b7;
	logic [11:0]          sx, sy;
	atsr_pkg::atsr_temp_t tsens, tv;
	logic [7:0]           tctl;
	logic                 en = 1'b1;
	logic [15:0]          q_e[$], q_m[$];
	int                   es[6] = '{0, 1, 2, 2, 1, 0};
	logic [5:0]           axv = 6'b001101;
	logic [5:0]           pmv = 6'b000110;
	int                   failures = 0;
	int                   n_tests = 0;
	int                   seed = 32'h932b5e74;
	int                   cyc = 0;

	atsr_top #(.TEMP_PERIOD_CYC(200), .TEMP_CONV_CYC(20)) i_atsr_top (.mclk(mclk),
		.arst_n(arst_n), .clk_en(en), .sclk(sclk), .accel_select_n(acc_n),
		.temp_select_n(tmp_n), .din(din), .dout(dout), .dout_oe(dout_oe),
		.accel_x_sample(sx), .accel_y_sample(sy), .temp_sensor(tsens), .accel_axis_y(ay),
		.accel_power_down(apd), .temp_ctrl(tctl), .temp_lockout(lock));
	// a released line reads inverted, so a bit sampled outside the driven window shows up
	atsr_host i_atsr_host (.sclk(sclk), .accel_select_n(acc_n), .temp_select_n(tmp_n),
		.din(din), .dout(dout_oe ? dout : ~dout));

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic end_of_test;
		if (failures == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test

	// temp read; a lead-only mask covers frames that may carry an older result
	task automatic trd(input logic [15:0] m);
		q_e.push_back({1'b0, tv, {5{tv[0]}}});
		q_m.push_back(m);
		i_atsr_host.xfer(1'b0, 16'h0000);
	endtask : trd

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// hang guard, well above the few thousand cycles the run needs
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			end_of_test();
		end
	end

	// each finished frame is held against the oldest note
	always @(i_atsr_host.got) begin
		chk(i_atsr_host.rx & q_m[0], q_e[0] & q_m[0]);
		void'(q_e.pop_front());
		void'(q_m.pop_front());
	end

	initial begin
		arst_n = 1'b0;
		sx = 12'($random(seed));
		sy = 12'($random(seed));
		tv = 10'($random(seed));
		tsens = tv;
		repeat (12) @(posedge mclk);
		#1 arst_n = 1'b1;
		#1 chk({4'h0, dout_oe, apd, ay, lock, tctl}, 16'h0000);
		repeat (300) @(posedge mclk);
		trd(16'h8000);
		repeat (50) @(posedge mclk);
		trd(16'hFFFF);
		chk({8'h00, tctl}, 16'h0000);
		// new sensor value while the restarted conversion runs under a fresh access
		@(posedge mclk);
		#1 tsens = 10'($random(seed));
		repeat (10) @(posedge mclk);
		trd(16'hFFFF);
		chk({15'h0, lock}, 16'h0001);
		// a low clock enable stalls the oscillator, so the lockout outlives the freeze
		@(posedge mclk);
		#1 en = 1'b0;
		repeat (300) @(posedge mclk);
		#1 en = 1'b1;
		repeat (150) @(posedge mclk);
		#1 chk({15'h0, lock}, 16'h0001);
		repeat (450) @(posedge mclk);
		#1 chk({15'h0, lock}, 16'h0000);
		tv = tsens;
		trd(16'h8000);
		repeat (50) @(posedge mclk);
		trd(16'hFFFF);
		// axis and power-down walk; the sample uses the previous control word
		for (int i = 0; i < 6; i++) begin
			@(posedge mclk);
			q_e.push_back(es[i] == 0 ? {4'h0, sx} : es[i] == 1 ? {4'h0, sy} : 16'h0000);
			q_m.push_back(16'hFFFF);
			b7 = 1'($random(seed));
			i_atsr_host.xfer(1'b1, {b7, 3'b000, axv[i], 2'b10, pmv[i], 8'h00});
			repeat (10) @(posedge mclk);
			#1 chk({14'h0, ay, apd}, {14'h0, axv[i], pmv[i]});
		end
		repeat (5) @(posedge mclk);
		end_of_test();
	end
endmodule : atsr_bench

bind atsr_top atsr_chk i_atsr_chk (.mclk(mclk), .arst_n(arst_n), .sclk(sclk),
	.accel_select_n(accel_select_n), .temp_select_n(temp_select_n), .din(din),
	.dout(dout), .dout_oe(dout_oe), .accel_axis_y(accel_axis_y),
	.accel_power_down(accel_power_down), .temp_ctrl(temp_ctrl), .temp_lockout(temp_lockout));
